//--- pkg/tsw_defines.vh
`ifndef TSW_DEFINES_VH
`define TSW_DEFINES_VH
// word offsets within a 32-bit task state segment (byte offset / 4)
`define TSW_OFF_LINK 5'h00
`define TSW_OFF_LEVEL0_STACK_OFFSET 5'h01
`define TSW_OFF_SS0 5'h02
`define TSW_OFF_PDB 5'h07
`define TSW_OFF_IP 5'h08
`define TSW_OFF_FLAGS 5'h09
`define TSW_OFF_GPR0 5'h0a
`define TSW_OFF_SEG0 5'h12
`define TSW_OFF_LDT 5'h18
`define TSW_OFF_TRAP 5'h19
`define TSW_LAST_WORD 5'h19
// gpr / segment counts
`define TSW_NUM_GPR 4'h8
`define TSW_NUM_SEG 4'h6
// dispatch kinds
`define TSW_KIND_CALL 2'h0
`define TSW_KIND_JMP 2'h1
`define TSW_KIND_INT 2'h2
`define TSW_KIND_EXC 2'h3
// descriptor type codes
`define TSW_TYPE_IDLE 4'h9
`define TSW_TYPE_BUSY 4'hb
// minimum descriptor limit
`define TSW_MIN_LIMIT 32'h00000067
// task register reset values
`define TSW_TR_SEL_RST 16'h0000
`define TSW_TR_BASE_RST 32'h00000000
`define TSW_TR_LIMIT_RST 32'h0000ffff
// fault codes
`define TSW_FLT_NONE 2'h0
`define TSW_FLT_LIMIT 2'h1
`define TSW_FLT_SELF 2'h2
`define TSW_FLT_BUSY 2'h3
`endif

//--- design/tsw_task_switch_sequencer.v
`timescale 1ns/10ps
`include "tsw_defines.vh"

// Notes on behaviour
// [RULE1] start on call, jump, interrupt, exception
// [RULE2] target named by gate or descriptor selector
// [RULE3] save outgoing context into own segment
// [RULE4] load incoming context, resume at new pointer
// [RULE5] callee segment gets caller selector link
// [RULE6] refuse dispatch to the running task
// [RULE7] handler tasks link back, nesting works
// [RULE8] load new local descriptor table selector
// [RULE9] reload page directory base every switch
// [RULE10] software loads task register first
// [RULE11] save eight general registers
// [RULE12] save six segment selectors
// [RULE13] save flags and instruction pointer
// [RULE14] link written only when return expected
// [RULE15] static fields read, never written
// [RULE16] page directory field is physical address
// [RULE17] three level stack selector plus offset
// [RULE18] trap bit raises debug exception
// [RULE19] io map base is 16-bit offset
// [RULE20] software keeps first 104 bytes mapped
// [RULE21] software marks segment pages writable
// [RULE22] busy type refuses call to busy task
// [RULE23] limit below minimum faults, no upper check
// [RULE24] task register resets to zero, ffff limit
// [RULE25] all saves finish before any load
module tsw_task_switch_sequencer (
    input wire ref_clk,
    input wire arst_n,
    // dispatch request from the core
    input wire dsp_req,
    input wire [1:0] dsp_kind,
    input wire dsp_via_gate,
    input wire [15:0] dsp_sel,
    input wire [31:0] dsp_base,
    input wire [31:0] dsp_limit,
    input wire [3:0] dsp_type,
    // load task register op
    input wire ltr_req,
    input wire [15:0] ltr_sel,
    input wire [31:0] ltr_base,
    input wire [31:0] ltr_limit,
    // outgoing context, flat: gpr 8x32, seg 6x16
    input wire [255:0] cur_gpr,
    input wire [95:0] cur_seg,
    input wire [31:0] cur_flags,
    input wire [31:0] cur_ip,
    // memory port, word accesses
    output reg mem_req,
    output reg mem_we,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    input wire mem_ack,
    input wire [31:0] mem_rdata,
    // results
    output reg busy,
    output reg done,
    output reg [1:0] fault,
    output reg fault_valid,
    output reg debug_trap,
    output reg [255:0] new_gpr,
    output reg [95:0] new_seg,
    output reg [31:0] new_flags,
    output reg [31:0] instruction_pointer,
    output reg [15:0] local_descriptor_table_sel,
    output reg [31:0] page_dir_base_register,
    output reg [15:0] io_map_base,
    output reg [15:0] tr_sel,
    output reg [31:0] tr_base,
    output reg [31:0] tr_limit,
    output reg [3:0] old_type,
    output reg [3:0] new_type,
    output reg type_update
);

    // sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_SAVE = 2'h1;
    localparam ST_LINK = 2'h2;
    localparam ST_LOAD = 2'h3;

    reg [1:0] state_reg;
    reg [4:0] word_reg;      // current word index in segment
    reg mem_pend_reg;        // access outstanding
    reg link_reg;            // return expected for this switch
    reg [15:0] tgt_sel_reg;
    reg [31:0] tgt_base_reg;
    reg [31:0] tgt_limit_reg;
    reg [15:0] tgt_link_sel_reg;  // caller selector written into callee
    reg [255:0] sav_gpr_reg;      // snapshot of context at dispatch
    reg [95:0] sav_seg_reg;
    reg [31:0] sav_flags_reg;
    reg [31:0] sav_ip_reg;

    // word to save at given index; static words are skipped
    reg [31:0] save_word;
    reg save_valid;
    integer i;
    // separate loop index for the clocked process, so each variable has one driver
    integer j;
    always @*
    begin
        save_word = 32'h00000000;
        save_valid = 1'b0;
        if (word_reg == `TSW_OFF_IP)
        begin
            save_word = sav_ip_reg; // RULE13
            save_valid = 1'b1;
        end
        else if (word_reg == `TSW_OFF_FLAGS)
        begin
            save_word = sav_flags_reg; // RULE13
            save_valid = 1'b1;
        end
        for (i = 0; i < 8; i = i + 1)
            if (word_reg == `TSW_OFF_GPR0 + i[4:0])
            begin
                save_word = sav_gpr_reg[i*32 +: 32]; // RULE11
                save_valid = 1'b1;
            end
        for (i = 0; i < 6; i = i + 1)
            if (word_reg == `TSW_OFF_SEG0 + i[4:0])
            begin
                save_word = {16'h0000, sav_seg_reg[i*16 +: 16]}; // RULE12
                save_valid = 1'b1;
            end
    end

    // dispatch checks, evaluated on the request cycle
    wire self_hit = (dsp_sel[15:3] == tr_sel[15:3]);
    wire is_call = (dsp_kind != `TSW_KIND_JMP);
    wire limit_bad = (dsp_limit < `TSW_MIN_LIMIT);
    wire busy_bad = is_call && (dsp_type == `TSW_TYPE_BUSY);

    // save walks words 0x08..0x17, load walks 0x01..last
    wire [4:0] save_first = `TSW_OFF_IP;
    wire [4:0] save_last = `TSW_OFF_SEG0 + 5'h05;
    wire [4:0] load_first = `TSW_OFF_LEVEL0_STACK_OFFSET;

    // main sequencer
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            word_reg <= 5'h00;
            mem_pend_reg <= 1'b0;
            link_reg <= 1'b0;
            tgt_sel_reg <= 16'h0000;
            tgt_base_reg <= 32'h00000000;
            tgt_limit_reg <= 32'h00000000;
            tgt_link_sel_reg <= 16'h0000;
            sav_gpr_reg <= 256'h0;
            sav_seg_reg <= 96'h0;
            sav_flags_reg <= 32'h00000000;
            sav_ip_reg <= 32'h00000000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_wdata <= 32'h00000000;
            busy <= 1'b0;
            done <= 1'b0;
            fault <= `TSW_FLT_NONE;
            fault_valid <= 1'b0;
            debug_trap <= 1'b0;
            new_gpr <= 256'h0;
            new_seg <= 96'h0;
            new_flags <= 32'h00000000;
            instruction_pointer <= 32'h00000000;
            local_descriptor_table_sel <= 16'h0000;
            page_dir_base_register <= 32'h00000000;
            io_map_base <= 16'h0000;
            tr_sel <= `TSW_TR_SEL_RST; // RULE24
            tr_base <= `TSW_TR_BASE_RST; // RULE24
            tr_limit <= `TSW_TR_LIMIT_RST; // RULE24
            old_type <= `TSW_TYPE_IDLE;
            new_type <= `TSW_TYPE_IDLE;
            type_update <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            fault_valid <= 1'b0;
            debug_trap <= 1'b0;
            type_update <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (ltr_req)
                    begin
                        // task register set up by software before switching
                        tr_sel <= ltr_sel; // RULE10
                        tr_base <= ltr_base;
                        tr_limit <= ltr_limit;
                    end
                    else if (dsp_req) // RULE1 RULE2
                    begin
                        if (self_hit)
                        begin
                            fault <= `TSW_FLT_SELF; // RULE6
                            fault_valid <= 1'b1;
                        end
                        else if (busy_bad)
                        begin
                            fault <= `TSW_FLT_BUSY; // RULE22
                            fault_valid <= 1'b1;
                        end
                        else if (limit_bad)
                        begin
                            fault <= `TSW_FLT_LIMIT; // RULE23
                            fault_valid <= 1'b1;
                        end
                        else
                        begin
                            // snapshot so the core may move on meanwhile
                            sav_gpr_reg <= cur_gpr;
                            sav_seg_reg <= cur_seg;
                            sav_flags_reg <= cur_flags;
                            sav_ip_reg <= cur_ip;
                            tgt_sel_reg <= dsp_sel;
                            tgt_base_reg <= dsp_base;
                            tgt_limit_reg <= dsp_limit;
                            tgt_link_sel_reg <= tr_sel;
                            link_reg <= is_call; // RULE5 RULE7 RULE14
                            fault <= `TSW_FLT_NONE;
                            busy <= 1'b1;
                            word_reg <= save_first;
                            state_reg <= ST_SAVE; // RULE3
                        end
                    end
                end
                ST_SAVE:
                begin
                    if (!mem_pend_reg)
                    begin
                        mem_req <= save_valid;
                        mem_we <= 1'b1;
                        mem_addr <= tr_base + {25'h0, word_reg, 2'b00};
                        mem_wdata <= save_word;
                        mem_pend_reg <= save_valid;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_pend_reg <= 1'b0;
                        if (word_reg == save_last)
                        begin
                            // every save completes before the first load
                            state_reg <= link_reg ? ST_LINK : ST_LOAD; // RULE25
                            word_reg <= load_first;
                        end
                        else
                            word_reg <= word_reg + 5'h01;
                    end
                end
                ST_LINK:
                begin
                    if (!mem_pend_reg)
                    begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= tgt_base_reg + {25'h0, `TSW_OFF_LINK, 2'b00};
                        mem_wdata <= {16'h0000, tgt_link_sel_reg}; // RULE5
                        mem_pend_reg <= 1'b1;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_pend_reg <= 1'b0;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    if (!mem_pend_reg)
                    begin
                        // loads are reads only; static fields never written
                        mem_req <= 1'b1;
                        mem_we <= 1'b0; // RULE15
                        mem_addr <= tgt_base_reg + {25'h0, word_reg, 2'b00}; // RULE17
                        mem_wdata <= 32'h00000000;
                        mem_pend_reg <= 1'b1;
                    end
                    else if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_pend_reg <= 1'b0;
                        // stack pointer words 1..6 are fetched but held by the core
                        if (word_reg == `TSW_OFF_PDB)
                            page_dir_base_register <= mem_rdata; // RULE9 RULE16
                        if (word_reg == `TSW_OFF_IP)
                            instruction_pointer <= mem_rdata; // RULE4
                        if (word_reg == `TSW_OFF_FLAGS)
                            new_flags <= mem_rdata;
                        for (j = 0; j < 8; j = j + 1)
                            if (word_reg == `TSW_OFF_GPR0 + j[4:0])
                                new_gpr[j*32 +: 32] <= mem_rdata;
                        for (j = 0; j < 6; j = j + 1)
                            if (word_reg == `TSW_OFF_SEG0 + j[4:0])
                                new_seg[j*16 +: 16] <= mem_rdata[15:0];
                        if (word_reg == `TSW_OFF_LDT)
                            local_descriptor_table_sel <= mem_rdata[15:0]; // RULE8
                        if (word_reg == `TSW_LAST_WORD)
                        begin
                            debug_trap <= mem_rdata[0]; // RULE18
                            io_map_base <= mem_rdata[31:16]; // RULE19
                            tr_sel <= tgt_sel_reg;
                            tr_base <= tgt_base_reg;
                            tr_limit <= tgt_limit_reg;
                            // jump frees old task; call keeps it busy for return
                            old_type <= link_reg ? `TSW_TYPE_BUSY : `TSW_TYPE_IDLE; // RULE22
                            new_type <= `TSW_TYPE_BUSY;
                            type_update <= 1'b1;
                            busy <= 1'b0;
                            done <= 1'b1; // RULE4
                            state_reg <= ST_IDLE;
                        end
                        else
                            word_reg <= word_reg + 5'h01;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule // tsw_task_switch_sequencer

//--- testbench/tsw_chk.sv
`timescale 1ns/10ps
module tsw_chk (
    input wire ref_clk,
    input wire arst_n,
    input wire dsp_req,
    input wire [1:0] dsp_kind,
    input wire [15:0] dsp_sel,
    input wire [31:0] dsp_limit,
    input wire [3:0] dsp_type,
    input wire ltr_req,
    input wire mem_req,
    input wire mem_we,
    input wire [31:0] mem_addr,
    input wire mem_ack,
    input wire busy,
    input wire done,
    input wire [1:0] fault,
    input wire fault_valid,
    input wire debug_trap,
    input wire [15:0] tr_sel,
    input wire [31:0] tr_base,
    input wire [31:0] tr_limit
);
    // set by the first load, cleared at completion
    reg loading_reg;
    // dispatch taken this edge, and which refusal applies
    wire take = !busy && dsp_req && !ltr_req;
    wire self_hit = dsp_sel[15:3] == tr_sel[15:3];
    // interrupt and exception dispatches are calls as well
    wire busy_call = dsp_kind != 2'h1 && dsp_type == 4'hb;
    // load phase tracker
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            loading_reg <= 1'b0;
        else if (done)
            loading_reg <= 1'b0;
        else if (mem_req && !mem_we)
            loading_reg <= 1'b1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_reset_task_reg: assert property (
        $rose(arst_n) |-> tr_sel == 16'h0000 && tr_limit == 32'h0000ffff) else $error("task register reset wrong");
    a_self_refused: assert property (
        take && self_hit |=> fault_valid && fault == 2'h2) else $error("self dispatch not refused");
    a_busy_call_refused: assert property (
        take && !self_hit && busy_call |=> fault_valid && fault == 2'h3) else $error("busy call not refused");
    a_short_limit: assert property (
        take && !self_hit && !busy_call && dsp_limit < 32'h67 |=> fault_valid && fault == 2'h1)
        else $error("short limit not refused");
    a_first_save: assert property (
        take && !self_hit && !busy_call && dsp_limit >= 32'h67 |-> ##2 mem_req && mem_we && mem_addr == tr_base + 32'h20)
        else $error("first save access wrong");
    a_req_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("request not held");
    a_ack_release: assert property (mem_ack |=> !mem_req) else $error("request kept after ack");
    a_save_before_load: assert property (loading_reg |-> !(mem_req && mem_we)) else $error("write after load");
    a_trap_with_done: assert property (debug_trap |-> done) else $error("trap outside completion");
    a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
endmodule // tsw_chk

bind tsw_task_switch_sequencer tsw_chk tsw_chk_inst (.*);

//--- testbench/tsw_mem_model.sv
`timescale 1ns/10ps
module tsw_mem_model (
    input wire ref_clk,
    input wire arst_n,
    input wire mem_req,
    input wire mem_we,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    output reg mem_ack,
    output reg [31:0] mem_rdata
);
    // word store, segments kept below 1 kbyte
    reg [31:0] mem [0:255];
    // extra wait cycles before each ack, set by the bench
    reg [3:0] wait_cyc = 4'h0;
    reg [3:0] cnt_reg;
    // every page always present and writable, so no access is ever refused
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_ack <= 1'b0;
            cnt_reg <= 4'h0;
            mem_rdata <= 32'h00000000;
        end
        else
        begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack)
            begin
                if (cnt_reg >= wait_cyc)
                begin
                    mem_ack <= 1'b1;
                    cnt_reg <= 4'h0;
                    if (mem_we)
                        mem[mem_addr[9:2]] <= mem_wdata;
                    else
                        mem_rdata <= mem[mem_addr[9:2]];
                end
                else
                    cnt_reg <= cnt_reg + 4'h1;
            end
            else if (!mem_ack)
                mem_rdata <= ~mem_rdata; // stale data never looks valid
        end
    end
endmodule // tsw_mem_model

//--- testbench/tb.sv
`timescale 1ns/10ps
`include "tsw_defines.vh"
module tb;
    reg ref_clk = 0, arst_n = 0, dsp_req = 0, dsp_via_gate = 0, ltr_req = 0;
    reg [1:0] dsp_kind = 0;
    reg [15:0] dsp_sel = 0, ltr_sel = 0, os;
    reg [31:0] dsp_base = 0, dsp_limit = 0, ltr_base = 0, ltr_limit = 0, cur_flags = 0, cur_ip = 0, ob;
    reg [3:0] dsp_type = 4'h9;
    reg [255:0] cur_gpr = 0;
    reg [95:0] cur_seg = 0;
    wire mem_req, mem_we, mem_ack, busy, done, fault_valid, debug_trap, type_update;
    wire [31:0] mem_addr, mem_wdata, mem_rdata, new_flags, instruction_pointer, page_dir_base_register, tr_base, tr_limit;
    wire [1:0] fault;
    wire [255:0] new_gpr;
    wire [95:0] new_seg;
    wire [15:0] local_descriptor_table_sel, io_map_base, tr_sel;
    wire [3:0] old_type, new_type;
    integer n_mismatch = 0, tests_run = 0, i;
    tsw_task_switch_sequencer tsw_task_switch_sequencer_inst (.*);
    tsw_mem_model mem_model_inst (.*);
    always #2 ref_clk = ~ref_clk;
    // word pattern unique to segment base and word index
    function [31:0] pat(input [31:0] b, input [4:0] w);
        pat = 32'ha5000000 | (b << 8) | w;
    endfunction
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task test_done;
    begin
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // one dispatch request, dropped after the accepting edge
    task t_dispatch(input [1:0] k, input [15:0] s, input [31:0] b, input [31:0] lim, input [3:0] ty);
    begin
        repeat (2) @(posedge ref_clk);
        #1;
        dsp_req = 1;
        dsp_kind = k;
        dsp_via_gate = k[1];
        dsp_sel = s;
        dsp_base = b;
        dsp_limit = lim;
        dsp_type = ty;
        @(posedge ref_clk);
        #1;
        dsp_req = 0;
    end
    endtask
    // full switch: saved words, link, loaded context
    task t_switch(input [1:0] k, input [15:0] s, input [31:0] b, input t);
        integer n;
        reg [31:0] e;
    begin
        for (n = 0; n < 26; n = n + 1)
            mem_model_inst.mem[b[9:2] + n] = pat(b, n[4:0]);
        mem_model_inst.mem[b[9:2] + 25] = {16'h0068, 15'h0000, t};
        for (n = 0; n < 8; n = n + 1)
            cur_gpr[32*n +: 32] = pat(32'h3c00 + s, n[4:0]);
        for (n = 0; n < 6; n = n + 1)
            cur_seg[16*n +: 16] = s + n + 1;
        cur_ip = pat(s, 5'h1f);
        cur_flags = pat(s, 5'h1e);
        t_dispatch(k, s, b, 32'h67, 4'h9);
        n = 0;
        while (done !== 1'b1 && n < 600)
        begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        chk("done", done, 1);
        chk("busy", busy, 0);
        chk("type upd", type_update, 1);
        chk("old type", old_type, (k == `TSW_KIND_JMP) ? `TSW_TYPE_IDLE : `TSW_TYPE_BUSY);
        chk("new type", new_type, `TSW_TYPE_BUSY);
        chk("trap", debug_trap, t);
        for (n = 0; n < 8; n = n + 1)
            chk("gpr save", mem_model_inst.mem[ob[9:2] + 10 + n], cur_gpr[32*n +: 32]);
        for (n = 0; n < 6; n = n + 1)
            chk("seg save", mem_model_inst.mem[ob[9:2] + 18 + n] & 32'hffff, cur_seg[16*n +: 16]);
        chk("ip save", mem_model_inst.mem[ob[9:2] + 8], cur_ip);
        chk("flags save", mem_model_inst.mem[ob[9:2] + 9], cur_flags);
        chk("static kept", mem_model_inst.mem[ob[9:2] + 7], pat(ob, 7));
        if (k == `TSW_KIND_JMP)
            chk("link kept", mem_model_inst.mem[b[9:2]], pat(b, 0));
        else
            chk("link", mem_model_inst.mem[b[9:2]] & 32'hffff, os);
        chk("ip", instruction_pointer, pat(b, 8));
        chk("gpr", new_gpr[255:224], pat(b, 17));
        chk("flags", new_flags, pat(b, 9));
        e = pat(b, 24);
        chk("ldt", local_descriptor_table_sel, e[15:0]);
        chk("pdb", page_dir_base_register, pat(b, 7));
        chk("io map", io_map_base, 16'h0068);
        chk("tr sel", tr_sel, s);
        chk("tr base", tr_base, b);
        chk("tr limit", tr_limit, 32'h67);
        e = pat(b, 18);
        chk("seg", new_seg[15:0], e[15:0]);
        os = s;
        ob = b;
    end
    endtask
    // refused dispatch: fault pulse, no memory traffic, task kept
    task t_refuse(input [1:0] k, input [15:0] s, input [31:0] lim, input [3:0] ty, input [1:0] f);
    begin
        // fault pulse stands only in the cycle right after the accepting edge
        t_dispatch(k, s, 32'h200, lim, ty);
        chk("fault valid", fault_valid, 1);
        chk("fault", fault, f);
        chk("no access", mem_req, 0);
        chk("tr kept", tr_sel, os);
    end
    endtask
    // watchdog, far beyond the expected several hundred cycles
    initial
    begin
        #40000;
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED watchdog expected finish seen hang");
        test_done;
    end
    initial
    begin
        for (i = 0; i < 26; i = i + 1)
            mem_model_inst.mem[i] = pat(0, i[4:0]);
        repeat (4) @(posedge ref_clk);
        #1;
        arst_n = 1;
        chk("reset sel", tr_sel, 0);
        chk("reset base", tr_base, 0);
        chk("reset limit", tr_limit, 32'h0000ffff);
        @(posedge ref_clk);
        #1;
        ltr_req = 1;
        ltr_sel = 16'h0008;
        ltr_limit = 32'h67;
        @(posedge ref_clk);
        #1;
        ltr_req = 0;
        os = 16'h0008;
        ob = 0;
        mem_model_inst.wait_cyc = 4'h2;
        t_switch(`TSW_KIND_CALL, 16'h0010, 32'h80, 1);
        mem_model_inst.wait_cyc = 4'h0;
        t_switch(`TSW_KIND_INT, 16'h0018, 32'h100, 0);
        t_refuse(`TSW_KIND_CALL, 16'h0018, 32'h67, 4'h9, `TSW_FLT_SELF);
        t_refuse(`TSW_KIND_CALL, 16'h0010, 32'h67, 4'hb, `TSW_FLT_BUSY);
        t_refuse(`TSW_KIND_JMP, 16'h0010, 32'h66, 4'h9, `TSW_FLT_LIMIT);
        t_switch(`TSW_KIND_EXC, 16'h0020, 32'h180, 0);
        t_switch(`TSW_KIND_JMP, 16'h0008, 32'h0, 0);
        test_done;
    end
endmodule // tb
